// ### core/irq_pkg.sv
package irq_pkg;
	localparam int NUM_EXT = 4;
	localparam int NUM_GROUPS = 10;
	localparam int NUM_TM = 8;
	localparam int NUM_CMP = 2;
	localparam int NUM_TICK = 2;
	localparam int NUM_SRC = 32;
	localparam int PC_W = 13;
	localparam int NUM_VEC = NUM_EXT + 1 + NUM_GROUPS;
	localparam int VEC_IDX_W = 4;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W = 4;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_EXT = 8'h04;
	localparam logic [7:0] ADDR_GROUP = 8'h08;
	localparam logic [7:0] ADDR_SRC_FLAG = 8'h0C;
	localparam logic [7:0] ADDR_SRC_EN = 8'h10;
	localparam logic [7:0] ADDR_SRC_MAP0 = 8'h14;
	localparam logic [7:0] ADDR_SRC_MAP1 = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;

	localparam int CTRL_GIE_BIT = 0;
	localparam int CTRL_ADE_BIT = 1;
	localparam int CTRL_ADF_BIT = 2;
	localparam int EXT_FLAG_LSB = 0;
	localparam int EXT_EN_LSB = 4;
	localparam int EXT_EDGE_LSB = 8;
	localparam int GROUP_EN_LSB = 16;
	localparam int MAP_FIELD_W = 4;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {
		EDGE_OFF,
		EDGE_RISE,
		EDGE_FALL,
		EDGE_BOTH
	} edge_mode_t;

	typedef struct packed {
		logic [NUM_EXT-1:0] ext_pins;
		logic conv_done;
		logic [NUM_SRC-1:0] src_event;
	} irq_events_t;

	typedef struct packed {
		logic take;
		logic [PC_W-1:0] vector;
		logic [PC_W-1:0] push_pc;
	} cpu_vector_t;

	// Vector table in priority order: index 0 is served first.
	localparam logic [PC_W-1:0] VEC_ADDR [NUM_VEC] = '{
		13'h0004, 13'h0008, 13'h000C, 13'h0010, 13'h0014,
		13'h0018, 13'h001C, 13'h0020, 13'h0024, 13'h0028,
		13'h002C, 13'h0030, 13'h0034, 13'h0038, 13'h003C
	};
	localparam int VEC_ADC = NUM_EXT;
	localparam int VEC_GROUP0 = NUM_EXT + 1;
endpackage : irq_pkg

// ### core/vectored_interrupt_controller.sv
`timescale 1ns/1ps
// Function
// - A source event sets its request flag regardless of enable.
// - A flag with its enable clear stays pending and never vectors.
// - Global enable low suppresses every vector jump.
// - Taking an interrupt pushes next PC and loads the vector address.
// - Return-from-interrupt pops the saved PC from the stack.
// - Servicing any interrupt clears the global enable in hardware.
// - Requests during blocked service still set and hold their flags.
// - A full stack blocks acknowledgement until the pointer decrements.
// - Simultaneous enabled requests are served in fixed priority order.
// - Any set flag wakes the device from sleep or idle.
// - Each external pin sets its flag on its selected transition.
// - Edge select offers rising, falling, both, or disabled.
// - Servicing an external interrupt clears its flag and global enable.
// - Conversion done sets its flag; service clears it.
// - Ten groups; a group flag sets when any member flag sets.
// - Group service clears only the group flag, not member flags.
// - Each timer has compare-A and compare-P flag and enable pairs.
// - Grouped source vectors only with global, own and group enables.
// - Comparator flag sets on output change; no hardware clear.
// - Tick flags set on overflow; software clears them.
module vectored_interrupt_controller
	import irq_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic [31:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire irq_pkg::irq_events_t EVENTS,
	input wire logic [PC_W-1:0] NEXT_PC,
	input wire logic RETURN_FROM_IRQ_INSTR,
	input wire logic INSTR_BOUNDARY,
	output irq_pkg::cpu_vector_t CPU_VEC,
	output logic [PC_W-1:0] RETURN_PC,
	output logic STACK_FULL,
	output logic WAKE_UP
);
	import irq_pkg::*;

	// Stack slots use just enough index bits for the depth
	localparam int STK_IDX_W = $clog2(STACK_DEPTH);
	// Only two map words exist: sources past them stay unmapped and
	// can wake the device but never vector
	localparam int MAP_WORD_W = 32;
	localparam int MAP1_LSB = MAP_WORD_W;

	// Register fields and the map layout fix these sizing limits
	if (NUM_SRC > MAP_WORD_W || NUM_EXT > EXT_EN_LSB ||
		NUM_GROUPS > GROUP_EN_LSB || NUM_GROUPS >= 2**MAP_FIELD_W ||
		NUM_VEC > 2**VEC_IDX_W || 2*MAP_WORD_W > MAP_FIELD_W*NUM_SRC ||
		STACK_DEPTH < 2 || STACK_DEPTH >= 2**SP_W ||
		2**STK_IDX_W != STACK_DEPTH)
	begin : g_bad_size
		$error("Unsupported interrupt controller sizing");
	end

	// Pins are asynchronous: two stages before anything looks at them
	logic [NUM_EXT-1:0] pin_s1_q;
	logic [NUM_EXT-1:0] pin_s2_q;
	logic [NUM_EXT-1:0] pin_prev_q;
	logic global_irq_enable_q;
	logic conv_done_flag_q;
	logic conv_done_enable_q;
	logic [NUM_EXT-1:0] ext_irq_flags_q;
	logic [NUM_EXT-1:0] ext_irq_enables_q;
	logic [2*NUM_EXT-1:0] ext_edge_select_q;
	logic [NUM_GROUPS-1:0] group_irq_flag_q;
	logic [NUM_GROUPS-1:0] group_irq_enable_q;
	logic [NUM_SRC-1:0] src_flag_q;
	logic [NUM_SRC-1:0] src_enable_q;
	logic [MAP_FIELD_W*NUM_SRC-1:0] src_map_q;
	logic [PC_W-1:0] stack_q [STACK_DEPTH];
	logic [SP_W-1:0] sp_q;
	cpu_vector_t cpu_vec_q;
	logic [31:0] prdata_q;

	logic [NUM_EXT-1:0] ext_hit;
	logic [NUM_SRC-1:0] src_rise;
	logic [NUM_GROUPS-1:0] group_set;
	logic [NUM_GROUPS-1:0] group_ready;
	logic [NUM_VEC-1:0] req_vec;
	logic take;
	logic [VEC_IDX_W-1:0] win_idx;
	logic pop;
	logic wr;
	logic rd;
	logic wr_ctrl;
	logic wr_ext;
	logic wr_group;
	logic wr_src_flag;
	logic wr_src_en;
	logic wr_map0;
	logic wr_map1;
	logic [NUM_SRC-1:0] src_clr;

	function automatic logic edge_hit(input logic [1:0] sel,
		input logic now, input logic prev);
		edge_mode_t m;
		m = edge_mode_t'(sel);
		case (m)
			EDGE_RISE: edge_hit = now & ~prev;
			EDGE_FALL: edge_hit = ~now & prev;
			EDGE_BOTH: edge_hit = now ^ prev;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	function automatic logic [MAP_FIELD_W-1:0] map_of(
		input logic [MAP_FIELD_W*NUM_SRC-1:0] m, input int i);
		map_of = m[i*MAP_FIELD_W +: MAP_FIELD_W];
	endfunction : map_of

	// Full-word compare, so aliases above the map read as unmapped
	function automatic logic reg_hit(input logic [31:0] a,
		input logic [7:0] off);
		reg_hit = (a == 32'(off));
	endfunction : reg_hit

	assign wr = PSEL & PENABLE & PWRITE;
	assign rd = PSEL & ~PENABLE & ~PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign PRDATA = prdata_q;
	assign CPU_VEC = cpu_vec_q;
	assign STACK_FULL = (sp_q == SP_W'(STACK_DEPTH));
	assign RETURN_PC = stack_q[STK_IDX_W'(sp_q - 1'b1)];
	assign pop = RETURN_FROM_IRQ_INSTR & (sp_q != '0);
	assign wr_ctrl = wr & reg_hit(PADDR, ADDR_CTRL);
	assign wr_ext = wr & reg_hit(PADDR, ADDR_EXT);
	assign wr_group = wr & reg_hit(PADDR, ADDR_GROUP);
	assign wr_src_flag = wr & reg_hit(PADDR, ADDR_SRC_FLAG);
	assign wr_src_en = wr & reg_hit(PADDR, ADDR_SRC_EN);
	assign wr_map0 = wr & reg_hit(PADDR, ADDR_SRC_MAP0);
	assign wr_map1 = wr & reg_hit(PADDR, ADDR_SRC_MAP1);

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_prev_q <= '0;
		end
		else
		begin
			pin_s1_q <= EVENTS.ext_pins;
			pin_s2_q <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	always_comb
	begin
		for (int i = 0; i < NUM_EXT; i++)
			ext_hit[i] = edge_hit(ext_edge_select_q[2*i +: 2],
				pin_s2_q[i], pin_prev_q[i]);
	end

	// Member sources: timer A/P pairs, comparators and ticks share this
	// vector of flags; the group each belongs to is software mapped.
	assign src_rise = EVENTS.src_event & ~src_flag_q;

	always_comb
	begin
		group_set = '0;
		group_ready = '0;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (map_of(src_map_q, i) < MAP_FIELD_W'(NUM_GROUPS))
			begin
				if (src_rise[i])
					group_set[map_of(src_map_q, i)] = 1'b1;
				if (src_flag_q[i] & src_enable_q[i])
					group_ready[map_of(src_map_q, i)] = 1'b1;
			end
		end
	end

	always_comb
	begin
		req_vec[NUM_EXT-1:0] = ext_irq_flags_q & ext_irq_enables_q;
		req_vec[VEC_ADC] = conv_done_flag_q & conv_done_enable_q;
		for (int g = 0; g < NUM_GROUPS; g++)
			req_vec[VEC_GROUP0+g] = group_irq_flag_q[g] &
				group_irq_enable_q[g] & group_ready[g];
	end

	always_comb
	begin
		win_idx = '0;
		for (int v = NUM_VEC - 1; v >= 0; v--)
			if (req_vec[v])
				win_idx = VEC_IDX_W'(v);
	end

	// Full stack or GIE low holds everything pending
	assign take = global_irq_enable_q & (|req_vec) & ~STACK_FULL &
		INSTR_BOUNDARY & ~RETURN_FROM_IRQ_INSTR;

	assign WAKE_UP = (|ext_irq_flags_q) | conv_done_flag_q |
		(|group_irq_flag_q) | (|src_flag_q);

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			cpu_vec_q <= '0;
		else
		begin
			cpu_vec_q.take <= take;
			cpu_vec_q.vector <= VEC_ADDR[win_idx];
			cpu_vec_q.push_pc <= NEXT_PC;
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			sp_q <= '0;
			for (int i = 0; i < STACK_DEPTH; i++)
				stack_q[i] <= '0;
		end
		else if (take)
		begin
			stack_q[STK_IDX_W'(sp_q)] <= NEXT_PC;
			sp_q <= sp_q + 1'b1;
		end
		else if (pop)
			sp_q <= sp_q - 1'b1;
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			global_irq_enable_q <= 1'b0;
		else if (take)
			global_irq_enable_q <= 1'b0;
		else if (wr_ctrl)
			global_irq_enable_q <= PWDATA[CTRL_GIE_BIT];
	end

	// Hardware set beats software clear in the same cycle
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			ext_irq_flags_q <= '0;
			ext_irq_enables_q <= '0;
			ext_edge_select_q <= '0;
		end
		else
		begin
			if (wr_ext)
			begin
				ext_irq_flags_q <= PWDATA[EXT_FLAG_LSB +: NUM_EXT] | ext_hit;
				ext_irq_enables_q <= PWDATA[EXT_EN_LSB +: NUM_EXT];
				ext_edge_select_q <= PWDATA[EXT_EDGE_LSB +: 2*NUM_EXT];
			end
			else
			begin
				for (int i = 0; i < NUM_EXT; i++)
					if (ext_hit[i])
						ext_irq_flags_q[i] <= 1'b1;
					else if (take && win_idx == VEC_IDX_W'(i))
						ext_irq_flags_q[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			conv_done_flag_q <= 1'b0;
			conv_done_enable_q <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				conv_done_enable_q <= PWDATA[CTRL_ADE_BIT];
			if (EVENTS.conv_done)
				conv_done_flag_q <= 1'b1;
			else if (take && win_idx == VEC_IDX_W'(VEC_ADC))
				conv_done_flag_q <= 1'b0;
			else if (wr_ctrl)
				conv_done_flag_q <= PWDATA[CTRL_ADF_BIT];
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			group_irq_flag_q <= '0;
			group_irq_enable_q <= '0;
		end
		else
		begin
			if (wr_group)
				group_irq_enable_q <= PWDATA[GROUP_EN_LSB +: NUM_GROUPS];
			for (int g = 0; g < NUM_GROUPS; g++)
				if (group_set[g])
					group_irq_flag_q[g] <= 1'b1;
				else if (take && win_idx == VEC_IDX_W'(VEC_GROUP0 + g))
					group_irq_flag_q[g] <= 1'b0;
				else if (wr_group)
					group_irq_flag_q[g] <= PWDATA[g];
		end
	end

	// Members are cleared only by writing 1s; service never touches them
	assign src_clr = wr_src_flag ? PWDATA[0 +: NUM_SRC] : '0;

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			src_flag_q <= '0;
		else
			src_flag_q <= EVENTS.src_event | (src_flag_q & ~src_clr);
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			src_enable_q <= '0;
			src_map_q <= {MAP_FIELD_W*NUM_SRC{1'b1}};
		end
		else if (wr_src_en)
			src_enable_q <= PWDATA[0 +: NUM_SRC];
		else if (wr_map0)
			src_map_q[0 +: MAP_WORD_W] <= PWDATA;
		else if (wr_map1)
			src_map_q[MAP1_LSB +: MAP_WORD_W] <= PWDATA;
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			prdata_q <= RESET_WORD;
		else if (rd)
		begin
			// Latched at setup so PRDATA stands through the access phase
			prdata_q <= RESET_WORD;
			if (reg_hit(PADDR, ADDR_CTRL))
			begin
				prdata_q[CTRL_GIE_BIT] <= global_irq_enable_q;
				prdata_q[CTRL_ADE_BIT] <= conv_done_enable_q;
				prdata_q[CTRL_ADF_BIT] <= conv_done_flag_q;
			end
			else if (reg_hit(PADDR, ADDR_EXT))
			begin
				prdata_q[EXT_FLAG_LSB +: NUM_EXT] <= ext_irq_flags_q;
				prdata_q[EXT_EN_LSB +: NUM_EXT] <= ext_irq_enables_q;
				prdata_q[EXT_EDGE_LSB +: 2*NUM_EXT] <= ext_edge_select_q;
			end
			else if (reg_hit(PADDR, ADDR_GROUP))
			begin
				prdata_q[0 +: NUM_GROUPS] <= group_irq_flag_q;
				prdata_q[GROUP_EN_LSB +: NUM_GROUPS] <= group_irq_enable_q;
			end
			else if (reg_hit(PADDR, ADDR_SRC_FLAG))
				prdata_q[0 +: NUM_SRC] <= src_flag_q;
			else if (reg_hit(PADDR, ADDR_SRC_EN))
				prdata_q[0 +: NUM_SRC] <= src_enable_q;
			else if (reg_hit(PADDR, ADDR_SRC_MAP0))
				prdata_q <= src_map_q[0 +: MAP_WORD_W];
			else if (reg_hit(PADDR, ADDR_SRC_MAP1))
				prdata_q <= src_map_q[MAP1_LSB +: MAP_WORD_W];
			else if (reg_hit(PADDR, ADDR_STATUS))
			begin
				prdata_q[0 +: SP_W] <= sp_q;
				prdata_q[SP_W] <= STACK_FULL;
			end
		end
	end
endmodule : vectored_interrupt_controller

// ### verif/vic_properties.sv
`timescale 1ns/1ps
module vic_properties
	import irq_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire irq_pkg::irq_events_t EVENTS,
	input wire logic [PC_W-1:0] NEXT_PC,
	input wire logic INSTR_BOUNDARY,
	input wire logic RETURN_FROM_IRQ_INSTR,
	input wire irq_pkg::cpu_vector_t CPU_VEC,
	input wire logic [PC_W-1:0] RETURN_PC,
	input wire logic STACK_FULL,
	input wire logic WAKE_UP
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	sequence s_pulse;
		CPU_VEC.take ##1 !CPU_VEC.take;
	endsequence
	a_take_once: assert property (CPU_VEC.take |-> s_pulse)
		else $error("take held longer than one cycle");
	a_push_next: assert property (CPU_VEC.take |->
		CPU_VEC.push_pc == $past(NEXT_PC))
		else $error("pushed pc differs from next pc");
	a_stack_top: assert property (CPU_VEC.take |->
		RETURN_PC == CPU_VEC.push_pc)
		else $error("stack top differs from pushed pc");
	a_at_boundary: assert property (CPU_VEC.take |->
		$past(INSTR_BOUNDARY))
		else $error("take off an instruction boundary");
	a_vec_table: assert property (CPU_VEC.take |->
		CPU_VEC.vector[1:0] == 2'h0 &&
		CPU_VEC.vector inside {[13'h0004:13'h003C]})
		else $error("vector outside table");
	a_full_blocks: assert property (STACK_FULL |=> !CPU_VEC.take)
		else $error("take while stack full");
	a_pop_frees: assert property (STACK_FULL &&
		RETURN_FROM_IRQ_INSTR |=> !STACK_FULL)
		else $error("pop left stack full");
	a_done_wakes: assert property (EVENTS.conv_done |->
		##[1:2] WAKE_UP)
		else $error("no wake after conversion done");
	a_apb_ok: assert property (PSEL |-> PREADY && !PSLVERR)
		else $error("apb not ready or error");
endmodule : vic_properties
bind vectored_interrupt_controller vic_properties u_vic_properties (
	.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .EVENTS(EVENTS), .NEXT_PC(NEXT_PC),
	.INSTR_BOUNDARY(INSTR_BOUNDARY), .RETURN_PC(RETURN_PC),
	.RETURN_FROM_IRQ_INSTR(RETURN_FROM_IRQ_INSTR), .CPU_VEC(CPU_VEC),
	.STACK_FULL(STACK_FULL), .WAKE_UP(WAKE_UP));

// ### verif/cpu_model.sv
`timescale 1ns/1ps
module cpu_model
	import irq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire irq_pkg::cpu_vector_t vec,
	input wire logic [PC_W-1:0] ret_pc,
	output logic [PC_W-1:0] next_pc,
	output logic boundary,
	output logic ret
);
	initial
	begin
		next_pc = 13'h0100;
		ret = 1'h0;
	end
	// Every fourth slot is mid-instruction, so takes are not always prompt
	assign boundary = next_pc[1:0] != 2'h3;
	always @(posedge clk)
	begin
		if (!rst_b)
			next_pc <= 13'h0100;
		else if (vec.take)
			next_pc <= vec.vector + 13'h0001;
		else if (ret)
			next_pc <= ret_pc;
		else
			next_pc <= next_pc + 13'h0001;
	end
	task automatic do_ret();
		@(posedge clk);
		ret <= 1'h1;
		@(posedge clk);
		ret <= 1'h0;
	endtask : do_ret
endmodule : cpu_model

// ### verif/vectored_interrupt_controller_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
	fails++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module vectored_interrupt_controller_test;
	import irq_pkg::*;
	logic mclk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic stack_full, wake_up, ret, bnd;
	logic [PC_W-1:0] npc, rpc, lastv;
	irq_events_t ev;
	cpu_vector_t cv;
	int fails, n_checks, takes, exp_takes;
	initial
	begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end
	vectored_interrupt_controller u_vectored_interrupt_controller (
		.MCLK(mclk), .RST_B(rst_b), .PADDR(paddr), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EVENTS(ev),
		.NEXT_PC(npc), .RETURN_FROM_IRQ_INSTR(ret), .INSTR_BOUNDARY(bnd),
		.CPU_VEC(cv), .RETURN_PC(rpc), .STACK_FULL(stack_full),
		.WAKE_UP(wake_up));
	cpu_model u_cpu_model (.clk(mclk), .rst_b(rst_b), .vec(cv),
		.ret_pc(rpc), .next_pc(npc), .boundary(bnd), .ret(ret));
	always @(posedge mclk)
	begin
		if (cv.take === 1'h1)
		begin
			takes++;
			lastv = cv.vector;
		end
	end
	task automatic results();
		if (fails == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {24'h000000, a};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do
			@(posedge mclk);
		while (pready !== 1'h1);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
	task automatic expect_take(input logic [PC_W-1:0] v);
		exp_takes++;
		repeat (40)
			if (takes < exp_takes)
				@(posedge mclk);
		`CHK(takes, exp_takes)
		`CHK(lastv, v)
	endtask : expect_take
	initial
	begin
		{psel, penable, pwrite, rst_b} = 4'h0;
		{paddr, pwdata} = 64'h0;
		ev = '0;
		repeat (12) @(posedge mclk);
		rst_b <= 1'h1;
		xfer(0, ADDR_CTRL, 0);
		`CHK(rd, RESET_WORD)
		`CHK(wake_up, 1'h0)
		xfer(0, 8'h40, 0);
		`CHK(rd, 32'h0)
		xfer(1, ADDR_EXT, 32'h3900);
		ev.ext_pins <= 4'hF;
		repeat (6) @(posedge mclk);
		ev.ext_pins <= 4'h0;
		repeat (6) @(posedge mclk);
		xfer(0, ADDR_EXT, 0);
		`CHK(rd, 32'h3907)
		`CHK(wake_up, 1'h1)
		xfer(1, ADDR_CTRL, 1);
		repeat (8) @(posedge mclk);
		`CHK(takes, 0)
		xfer(1, ADDR_CTRL, 0);
		xfer(1, ADDR_EXT, 32'h39F7);
		repeat (8) @(posedge mclk);
		`CHK(takes, 0)
		for (int i = 0; i < 3; i++)
		begin
			xfer(1, ADDR_CTRL, 1);
			expect_take(VEC_ADDR[i]);
			if (i == 0)
			begin
				ev.conv_done <= 1'h1;
				@(posedge mclk);
				ev.conv_done <= 1'h0;
				xfer(0, ADDR_CTRL, 0);
				`CHK(rd, 32'h4)
			end
			u_cpu_model.do_ret();
		end
		xfer(0, ADDR_EXT, 0);
		`CHK(rd, 32'h39F0)
		xfer(1, ADDR_CTRL, 32'h7);
		expect_take(VEC_ADDR[VEC_ADC]);
		xfer(0, ADDR_CTRL, 0);
		`CHK(rd, 32'h2)
		u_cpu_model.do_ret();
		xfer(1, ADDR_SRC_MAP0, 32'hFFFF_FFF3);
		xfer(1, ADDR_SRC_EN, 1);
		xfer(1, ADDR_CTRL, 1);
		ev.src_event[0] <= 1'h1;
		@(posedge mclk);
		ev.src_event[0] <= 1'h0;
		repeat (8) @(posedge mclk);
		`CHK(takes, exp_takes)
		xfer(0, ADDR_GROUP, 0);
		`CHK(rd, 32'h8)
		xfer(1, ADDR_GROUP, 32'h0008_0008);
		expect_take(VEC_ADDR[VEC_GROUP0 + 3]);
		xfer(0, ADDR_GROUP, 0);
		`CHK(rd, 32'h0008_0000)
		xfer(0, ADDR_SRC_FLAG, 0);
		`CHK(rd, 32'h1)
		xfer(1, ADDR_SRC_FLAG, 1);
		xfer(0, ADDR_SRC_FLAG, 0);
		`CHK(rd, 32'h0)
		u_cpu_model.do_ret();
		// Both-edge pin gives a fresh request on every toggle
		xfer(1, ADDR_EXT, 32'h3940);
		for (int i = 0; i < 9; i++)
		begin
			ev.ext_pins[2] <= ~ev.ext_pins[2];
			repeat (5) @(posedge mclk);
			xfer(1, ADDR_CTRL, 1);
			if (i == 8)
			begin
				repeat (20) @(posedge mclk);
				`CHK(takes, exp_takes)
				`CHK(stack_full, 1'h1)
				xfer(0, ADDR_STATUS, 0);
				`CHK(rd, 32'h18)
				u_cpu_model.do_ret();
			end
			expect_take(VEC_ADDR[2]);
		end
		repeat (8) u_cpu_model.do_ret();
		xfer(0, ADDR_STATUS, 0);
		`CHK(rd, 32'h0)
		results();
	end
	initial
	begin
		repeat (5000) @(posedge mclk);
		fails++;
		results();
	end
endmodule : vectored_interrupt_controller_test
